//--- src/add_sub_pkg.sv
// Shared constants, operation codes and operand-class helpers for the
// add and subtract datapath.
// Assumes a 16-entry register set with stack pointer and program counter
// at the usual high indices.
package add_sub_pkg;

    // ****************************************************************
    // Widths and register indices
    // ****************************************************************
    localparam int          DATA_W     = 32;
    localparam int          IDX_W      = 4;
    localparam int          IMM_W      = 10;
    localparam logic [3:0]  SP_INDEX   = 4'hD;
    localparam logic [3:0]  PC_INDEX   = 4'hF;
    localparam logic [3:0]  LOW_LAST   = 4'h7;

    // ****************************************************************
    // Immediate limits
    // ****************************************************************
    localparam logic [9:0]  IMM_BASE_MAX   = 10'h3FC;
    localparam logic [9:0]  IMM_SP_MAX     = 10'h1FC;
    localparam logic [9:0]  IMM_SHORT_MAX  = 10'h007;
    localparam logic [9:0]  IMM_BYTE_MAX   = 10'h0FF;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic        FLAG_RESET     = 1'h0;
    localparam logic [31:0] DATA_RESET     = 32'h0000_0000;
    localparam logic [3:0]  INDEX_RESET    = 4'h0;

    // ****************************************************************
    // Operation codes
    // ****************************************************************
    typedef enum logic [2:0] {
        PLAIN_ADD_OP               = 3'b000,
        FLAG_SETTING_ADD_OP        = 3'b001,
        ADD_WITH_CARRY_OP          = 3'b010,
        PLAIN_SUBTRACT_OP          = 3'b011,
        FLAG_SETTING_SUBTRACT_OP   = 3'b100,
        SUBTRACT_WITH_CARRY_OP     = 3'b101,
        NEGATE_REVERSE_SUBTRACT_OP = 3'b110
    } alu_op_t;

    // True when the index names one of the eight low registers.
    function automatic logic is_low(input logic [3:0] idx);
        is_low = (idx <= LOW_LAST);
    endfunction

    // True when the operation updates the condition flags.
    function automatic logic is_flag_op(input alu_op_t op);
        is_flag_op = (op != PLAIN_ADD_OP) && (op != PLAIN_SUBTRACT_OP);
    endfunction

    // True when an immediate is a whole multiple of four within a limit.
    function automatic logic word_imm_ok(input logic [9:0] imm, input logic [9:0] lim);
        word_imm_ok = (imm[1:0] == 2'h0) && (imm <= lim);
    endfunction

endpackage

//--- src/add_flag_unit.sv
// 32-bit adder with carry in, giving sum, carry out and signed overflow.
// Assumes the caller inverts the second operand for subtraction.
`timescale 1ns/1ps
`default_nettype none
module add_flag_unit
    import add_sub_pkg::*;
(
    input  wire logic [31:0] addend_a,
    input  wire logic [31:0] addend_b,
    input  wire logic        carry_in,
    output logic      [31:0] sum,
    output logic             carry_out,
    output logic             overflow
);

    logic [32:0] wide_sum;

    // The extra top bit holds the unsigned carry; overflow is signed.
    always_comb
    begin
        wide_sum  = {1'b0, addend_a} + {1'b0, addend_b} + {32'h0, carry_in};
        sum       = wide_sum[31:0];
        carry_out = wide_sum[32];
        overflow  = (addend_a[31] == addend_b[31]) && (wide_sum[31] != addend_a[31]);
    end

endmodule
`default_nettype wire

//--- src/operand_check.sv
// Legality check of register and immediate operand forms.
// Assumes the destination index is already resolved by the caller.
`timescale 1ns/1ps
`default_nettype none
module operand_check
    import add_sub_pkg::*;
(
    input  wire alu_op_t    op_code,
    input  wire logic       use_imm,
    input  wire logic [3:0] dest_index,
    input  wire logic [3:0] first_index,
    input  wire logic [3:0] second_index,
    input  wire logic [9:0] imm_value,
    output logic            legal
);

    logic all_low;
    logic same_dest;
    logic short_imm;

    // Classify the operands once, then test each operation's forms.
    always_comb
    begin
        all_low   = is_low(dest_index) && is_low(first_index)
                    && (use_imm || is_low(second_index));
        same_dest = (dest_index == first_index);
        short_imm = all_low && (imm_value <= IMM_SHORT_MAX);
        legal     = 1'b0;
        case (op_code)
            ADD_WITH_CARRY_OP, SUBTRACT_WITH_CARRY_OP:
                legal = !use_imm && all_low && same_dest;  // RULE_11
            NEGATE_REVERSE_SUBTRACT_OP:
                legal = !use_imm && is_low(dest_index) && is_low(first_index);  // RULE_11
            PLAIN_ADD_OP:
                if (use_imm)
                    legal = (is_low(dest_index)
                             && (first_index == SP_INDEX || first_index == PC_INDEX)
                             && word_imm_ok(imm_value, IMM_BASE_MAX))  // RULE_09
                          || (dest_index == SP_INDEX && first_index == SP_INDEX
                             && word_imm_ok(imm_value, IMM_SP_MAX))
                          || short_imm;  // RULE_10
                else
                    legal = same_dest
                          && !(first_index == PC_INDEX && second_index == PC_INDEX);  // RULE_08
            PLAIN_SUBTRACT_OP:
                if (use_imm)
                    legal = (dest_index == SP_INDEX && first_index == SP_INDEX
                             && word_imm_ok(imm_value, IMM_SP_MAX))  // RULE_09
                          || short_imm;  // RULE_10
                else
                    legal = all_low;
            FLAG_SETTING_ADD_OP, FLAG_SETTING_SUBTRACT_OP:
                if (use_imm)
                    legal = short_imm
                          || (all_low && same_dest && imm_value <= IMM_BYTE_MAX);  // RULE_10
                else
                    legal = all_low;  // RULE_11
            default:
                legal = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

//--- src/add_subtract_datapath.sv
// Add and subtract datapath: takes one decoded operation per cycle, gives
// the result and destination index one cycle later and keeps the flags.
// Assumes the decoder supplies register values and indices on ref_clk.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RULE_01] With no destination given, the result goes to the first source register.
// [RULE_02] Add with carry sums both sources plus the carry flag and updates all four flags.
// [RULE_03] Plain add sums the first source with a register or immediate and keeps the flags.
// [RULE_04] Flag-setting add gives the plain add sum and updates all four flags.
// [RULE_05] Reverse subtract gives zero minus the source and updates all four flags.
// [RULE_06] Subtract with carry takes one more off when carry is clear and updates the flags.
// [RULE_07] Plain subtract keeps the flags while flag-setting subtract updates them.
// [RULE_08] Register plain add takes any register but needs destination equal to first source and not two program counters.
// [RULE_09] Stack pointer and program counter immediate forms take word multiples up to 1020 or 508.
// [RULE_10] Low three-operand immediates reach 7, and flag-setting forms with destination equal source reach 255.
// [RULE_11] Carry, reverse and register flag-setting forms take only low registers, carry forms with destination equal first source.
// [RULE_12] Software chains multiword arithmetic with a flag-setting low word then carry forms, registers in any order.
// [RULE_13] Negative is bit 31, zero an all-zero result, carry an unsigned carry or no borrow, overflow a signed overflow.
// [RULE_14] All results wrap modulo two to the thirty-second with immediates zero-extended.
module add_subtract_datapath
    import add_sub_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        op_valid,
    input  wire alu_op_t     op_code,
    input  wire logic        use_imm,
    input  wire logic        dest_present,
    input  wire logic [3:0]  dest_index,
    input  wire logic [3:0]  first_source_register,
    input  wire logic [3:0]  second_source_register,
    input  wire logic [31:0] first_source_value,
    input  wire logic [31:0] second_source_value,
    input  wire logic [9:0]  imm_value,
    output logic             wr_en,
    output logic      [3:0]  wr_index,
    output logic      [31:0] wr_data,
    output logic             flag_n,
    output logic             flag_z,
    output logic             flag_c,
    output logic             flag_v,
    output logic             flag_update,
    output logic             illegal_op
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic        wr_en;
        logic [3:0]  wr_index;
        logic [31:0] wr_data;
        logic        flag_n;
        logic        flag_z;
        logic        flag_c;
        logic        flag_v;
        logic        flag_update;
        logic        illegal;
    } datapath_state_t;

    localparam datapath_state_t STATE_RESET = '{
        wr_en:       1'b0,
        wr_index:    INDEX_RESET,
        wr_data:     DATA_RESET,
        flag_n:      FLAG_RESET,
        flag_z:      FLAG_RESET,
        flag_c:      FLAG_RESET,
        flag_v:      FLAG_RESET,
        flag_update: 1'b0,
        illegal:     1'b0
    };

    datapath_state_t state_reg;
    datapath_state_t state_next;

    logic [3:0]  resolved_dest;
    logic [31:0] second_operand;
    logic [31:0] addend_a;
    logic [31:0] addend_b;
    logic        carry_in;
    logic [31:0] sum;
    logic        carry_out;
    logic        overflow;
    logic        legal;

    // ****************************************************************
    // Operand preparation
    // ****************************************************************

    // A missing destination falls back to the first source register.
    assign resolved_dest = dest_present ? dest_index : first_source_register;  // RULE_01

    // Immediates are zero-extended so the sum wraps at 32 bits.
    assign second_operand = use_imm ? {22'h0, imm_value} : second_source_value;  // RULE_14

    // Subtraction is done as addition of the inverted operand, so the
    // adder carry out is directly the no-borrow flag.
    always_comb
    begin
        addend_a = first_source_value;
        addend_b = second_operand;
        carry_in = 1'b0;
        case (op_code)
            ADD_WITH_CARRY_OP:
            begin
                addend_b = second_source_value;
                carry_in = state_reg.flag_c;  // RULE_02
            end
            PLAIN_ADD_OP, FLAG_SETTING_ADD_OP:
                carry_in = 1'b0;  // RULE_03
            PLAIN_SUBTRACT_OP, FLAG_SETTING_SUBTRACT_OP:
            begin
                addend_b = ~second_operand;  // RULE_07
                carry_in = 1'b1;
            end
            SUBTRACT_WITH_CARRY_OP:
            begin
                addend_b = ~second_source_value;
                carry_in = state_reg.flag_c;  // RULE_06
            end
            NEGATE_REVERSE_SUBTRACT_OP:
            begin
                addend_a = DATA_RESET;
                addend_b = ~first_source_value;  // RULE_05
                carry_in = 1'b1;
            end
            default:
                carry_in = 1'b0;
        endcase
    end

    // ****************************************************************
    // Arithmetic and operand checks
    // ****************************************************************

    // Shared adder for every operation.
    add_flag_unit u_adder (
        .addend_a  (addend_a),
        .addend_b  (addend_b),
        .carry_in  (carry_in),
        .sum       (sum),
        .carry_out (carry_out),
        .overflow  (overflow)
    );

    // Operand form legality; an illegal form writes nothing.
    operand_check u_check (
        .op_code      (op_code),
        .use_imm      (use_imm),
        .dest_index   (resolved_dest),
        .first_index  (first_source_register),
        .second_index (second_source_register),
        .imm_value    (imm_value),
        .legal        (legal)
    );

    // ****************************************************************
    // Next state and registers
    // ****************************************************************

    // Write strobes are single-cycle; flags change only on legal
    // flag-setting operations and otherwise hold.
    always_comb
    begin
        state_next             = state_reg;
        state_next.wr_en       = 1'b0;
        state_next.flag_update = 1'b0;
        state_next.illegal     = 1'b0;
        if (op_valid)
        begin
            if (legal)
            begin
                state_next.wr_en    = 1'b1;
                state_next.wr_index = resolved_dest;  // RULE_01
                state_next.wr_data  = sum;  // RULE_14
                if (is_flag_op(op_code))
                begin
                    state_next.flag_n      = sum[31];  // RULE_13
                    state_next.flag_z      = (sum == DATA_RESET);
                    state_next.flag_c      = carry_out;
                    state_next.flag_v      = overflow;
                    state_next.flag_update = 1'b1;  // RULE_04
                end
            end
            else
            begin
                state_next.illegal = 1'b1;  // RULE_11
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_reg <= STATE_RESET;
        else
            state_reg <= state_next;
    end

    // Outputs come straight from the state register.
    assign wr_en       = state_reg.wr_en;
    assign wr_index    = state_reg.wr_index;
    assign wr_data     = state_reg.wr_data;
    assign flag_n      = state_reg.flag_n;
    assign flag_z      = state_reg.flag_z;
    assign flag_c      = state_reg.flag_c;
    assign flag_v      = state_reg.flag_v;
    assign flag_update = state_reg.flag_update;
    assign illegal_op  = state_reg.illegal;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Two-operand form lands in the first source register.
    AST_DEST_DEFAULT: assert property (  // RULE_01
        op_valid && legal && !dest_present
        |=> wr_en && wr_index == $past(first_source_register))
        else $error("missing destination not mapped to first source");

    // Carry-in add includes the previous carry flag.
    AST_ADC_SUM: assert property (  // RULE_02
        op_valid && legal && op_code == ADD_WITH_CARRY_OP
        |=> flag_update && wr_data == $past(first_source_value)
            + $past(second_source_value) + {31'h0, $past(flag_c)})
        else $error("add with carry sum wrong");

    // Plain add and subtract leave all four flags as they were.
    AST_PLAIN_KEEPS_FLAGS: assert property (  // RULE_03
        op_valid && (op_code == PLAIN_ADD_OP || op_code == PLAIN_SUBTRACT_OP)
        |=> !flag_update && $stable({flag_n, flag_z, flag_c, flag_v}))
        else $error("plain operation changed flags");

    // Flag-setting add carries out exactly on unsigned wrap.
    AST_ADDS_CARRY: assert property (  // RULE_04
        op_valid && legal && op_code == FLAG_SETTING_ADD_OP
        |=> flag_c == (wr_data < $past(first_source_value)))
        else $error("flag-setting add carry wrong");

    // Negation is zero minus the source; carry only for a zero source.
    AST_RSB_NEGATE: assert property (  // RULE_05
        op_valid && legal && op_code == NEGATE_REVERSE_SUBTRACT_OP
        |=> wr_data == DATA_RESET - $past(first_source_value)
            && flag_c == ($past(first_source_value) == DATA_RESET))
        else $error("reverse subtract wrong");

    // Subtract with carry borrows one extra when carry was clear.
    AST_SBC_DIFF: assert property (  // RULE_06
        op_valid && legal && op_code == SUBTRACT_WITH_CARRY_OP
        |=> wr_data == $past(first_source_value) - $past(second_source_value)
            - {31'h0, !$past(flag_c)})
        else $error("subtract with carry wrong");

    // Flag-setting subtract: no-borrow carry tracks unsigned compare.
    AST_FLAG_SETTING_SUBTRACT_OP_CARRY: assert property (  // RULE_07
        op_valid && legal && op_code == FLAG_SETTING_SUBTRACT_OP && !use_imm
        |=> flag_c == ($past(first_source_value) >= $past(second_source_value)))
        else $error("flag-setting subtract carry wrong");

    // Two program counter sources are refused and nothing is written.
    AST_PC_PAIR_REFUSED: assert property (  // RULE_08
        op_valid && op_code == PLAIN_ADD_OP && !use_imm
        && first_source_register == PC_INDEX && second_source_register == PC_INDEX
        |=> illegal_op && !wr_en)
        else $error("double program counter add accepted");

    // A stack pointer immediate not a word multiple is refused.
    AST_SP_IMM_ALIGN: assert property (  // RULE_09
        op_valid && op_code == PLAIN_SUBTRACT_OP && use_imm
        && first_source_register == SP_INDEX && imm_value[1:0] != 2'h0
        |=> illegal_op ##1 !illegal_op || $past(op_valid))
        else $error("misaligned stack pointer immediate accepted");

    // Flag-setting add immediates above 7 need destination equal to source.
    AST_IMM_RANGE: assert property (  // RULE_10
        op_valid && op_code == FLAG_SETTING_ADD_OP && use_imm
        && imm_value > IMM_SHORT_MAX && resolved_dest != first_source_register
        |=> illegal_op && $stable({flag_n, flag_z, flag_c, flag_v}))
        else $error("wide immediate with distinct destination accepted");

    // Add with carry with a high second source register is refused.
    AST_HIGH_REG_REFUSED: assert property (  // RULE_11
        op_valid && op_code == ADD_WITH_CARRY_OP && !is_low(second_source_register)
        |=> illegal_op && !flag_update)
        else $error("carry form with high register accepted");

    // Negative and zero follow the written result.
    AST_NZ_FROM_RESULT: assert property (  // RULE_13
        flag_update |-> wr_en && flag_n == wr_data[31] && flag_z == (wr_data == DATA_RESET))
        else $error("negative or zero flag does not match result");

    // Immediate add wraps with a zero-extended immediate.
    AST_IMM_WRAP: assert property (  // RULE_14
        op_valid && legal && op_code == PLAIN_ADD_OP && use_imm
        |=> wr_data == $past(first_source_value) + {22'h0, $past(imm_value)})
        else $error("immediate add result wrong");

endmodule
`default_nettype wire

//--- verification/add_subtract_datapath_tb_top.sv
// Self-checking bench of the add and subtract datapath.
// Assumes the package add_sub_pkg and a one-cycle answer latency.
`timescale 1ns/1ps
`default_nettype none
module add_subtract_datapath_tb_top;
    import add_sub_pkg::*;
    // ************************************************
    // Stimulus record and signals
    // ************************************************
    typedef struct {
        logic        v;
        alu_op_t     op;
        logic        ui;
        logic        dp;
        logic [3:0]  d;
        logic [3:0]  f;
        logic [3:0]  s;
        logic [31:0] a;
        logic [31:0] b;
        logic [9:0]  imm;
    } op_rec_t;
    logic        ref_clk, sys_rst, op_valid, use_imm, dest_present;
    alu_op_t     op_code;
    logic [3:0]  dest_index, first_src, second_src, wr_index;
    logic [31:0] first_val, second_val, wr_data;
    logic [9:0]  imm_value;
    logic        wr_en, flag_n, flag_z, flag_c, flag_v, flag_update, illegal_op;
    logic        mn, mz, mc, mv;
    int          mismatches, tests_run;
    op_rec_t     p, idle;
    add_subtract_datapath add_subtract_datapath_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .op_valid(op_valid), .op_code(op_code), .use_imm(use_imm),
        .dest_present(dest_present), .dest_index(dest_index),
        .first_source_register(first_src), .second_source_register(second_src),
        .first_source_value(first_val), .second_source_value(second_val),
        .imm_value(imm_value), .wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data),
        .flag_n(flag_n), .flag_z(flag_z), .flag_c(flag_c), .flag_v(flag_v),
        .flag_update(flag_update), .illegal_op(illegal_op));
    // The clock toggles every half period of 10 ns.
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ************************************************
    // Checking helpers
    // ************************************************
    task automatic cmp_bit(logic got, logic exp, string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic cmp_word(logic [31:0] got, logic [31:0] exp, string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Works out whether the operand form is accepted, with the destination resolved.
    function automatic logic legal_form(op_rec_t r);
        logic [3:0] d;
        logic       lo, m4, sl;
        d  = r.dp ? r.d : r.f;
        lo = (d <= LOW_LAST) && (r.f <= LOW_LAST);
        sl = lo && (r.s <= LOW_LAST);
        m4 = (r.imm[1:0] == 2'h0);
        case (r.op)
            PLAIN_ADD_OP: legal_form = r.ui ? ((d <= LOW_LAST && (r.f == SP_INDEX
                || r.f == PC_INDEX) && m4 && r.imm <= IMM_BASE_MAX) || (lo && r.imm <= 10'h007)
                || (d == SP_INDEX && r.f == SP_INDEX && m4 && r.imm <= IMM_SP_MAX))
                : (d == r.f && !(r.f == PC_INDEX && r.s == PC_INDEX));
            PLAIN_SUBTRACT_OP: legal_form = r.ui ? ((lo && r.imm <= 10'h007)
                || (d == SP_INDEX && r.f == SP_INDEX && m4 && r.imm <= IMM_SP_MAX)) : sl;
            FLAG_SETTING_ADD_OP, FLAG_SETTING_SUBTRACT_OP: legal_form = r.ui ?
                (lo && (r.imm <= 10'h007 || (d == r.f && r.imm <= IMM_BYTE_MAX))) : sl;
            ADD_WITH_CARRY_OP, SUBTRACT_WITH_CARRY_OP: legal_form = !r.ui && sl && d == r.f;
            NEGATE_REVERSE_SUBTRACT_OP: legal_form = !r.ui && lo;
            default: legal_form = 1'b0;
        endcase
    endfunction
    // Compares the answer to the previous operation and advances the model flags.
    task automatic check_prev();
        logic        ok, fl, ci, co;
        logic [31:0] x, y, r, b;
        ok = p.v && legal_form(p);
        fl = ok && p.op != PLAIN_ADD_OP && p.op != PLAIN_SUBTRACT_OP;
        b  = p.ui ? {22'h0, p.imm} : p.b;
        x  = p.a;
        y  = ~b;
        ci = 1'b1;
        if (p.op == PLAIN_ADD_OP || p.op == FLAG_SETTING_ADD_OP || p.op == ADD_WITH_CARRY_OP)
        begin
            y  = b;
            ci = 1'b0;
        end
        if (p.op == ADD_WITH_CARRY_OP || p.op == SUBTRACT_WITH_CARRY_OP)
            ci = mc;
        if (p.op == NEGATE_REVERSE_SUBTRACT_OP)
        begin
            x = 32'h0;
            y = ~p.a;
        end
        {co, r} = {1'b0, x} + {1'b0, y} + {32'h0, ci};
        cmp_bit(wr_en, ok, "write strobe");
        cmp_bit(illegal_op, p.v && !ok, "refusal strobe");
        cmp_bit(flag_update, fl, "flag strobe");
        if (ok)
        begin
            cmp_word({28'h0, wr_index}, {28'h0, p.dp ? p.d : p.f}, "destination");
            cmp_word(wr_data, r, "result");
        end
        if (fl)
            {mn, mz, mc, mv} = {r[31], r == 32'h0, co, (x[31] == y[31]) && (r[31] != x[31])};
        cmp_word({28'h0, flag_n, flag_z, flag_c, flag_v}, {28'h0, mn, mz, mc, mv}, "flags");
    endtask
    // Drives one record at a rising edge and checks the answer to the one before.
    task automatic step(op_rec_t r);
        @(posedge ref_clk);
        op_valid     <= r.v;
        op_code      <= r.op;
        use_imm      <= r.ui;
        dest_present <= r.dp;
        dest_index   <= r.d;
        first_src    <= r.f;
        second_src   <= r.s;
        first_val    <= r.a;
        second_val   <= r.b;
        imm_value    <= r.imm;
        #1;
        check_prev();
        p = r;
    endtask
    function automatic op_rec_t mk(alu_op_t op, logic ui, logic dp, logic [3:0] d, logic [3:0] f,
        logic [3:0] s, logic [31:0] a, logic [31:0] b, logic [9:0] imm);
        mk = '{1'b1, op, ui, dp, d, f, s, a, b, imm};
    endfunction
    // Random record biased towards low registers and boundary values.
    function automatic op_rec_t rnd();
        op_rec_t r;
        r = mk(alu_op_t'($urandom_range(7)), 1'($urandom_range(1)), 1'($urandom_range(1)),
            4'($urandom_range(($urandom_range(3) == 0) ? 15 : 7)), 4'($urandom_range(7)),
            4'($urandom_range(($urandom_range(3) == 0) ? 15 : 7)), $urandom, $urandom, 10'h0);
        r.v   = ($urandom_range(7) != 0);
        r.imm = 10'($urandom_range(($urandom_range(1) == 0) ? 1023 : 15));
        if ($urandom_range(3) == 0)
            r.f = ($urandom_range(1) == 0) ? SP_INDEX : PC_INDEX;
        if ($urandom_range(1) == 0)
            r.d = r.f;
        if ($urandom_range(5) == 0)
            r.a = 32'h7FFF_FFFF + 32'($urandom_range(1));
        if (r.op == NEGATE_REVERSE_SUBTRACT_OP)
            r.ui = 1'b0;
        return r;
    endfunction
    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst  <= 1'b1;
        op_valid <= 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        cmp_word(wr_data | {20'h0, wr_index, wr_en, illegal_op, flag_update, flag_n, flag_z,
            flag_c, flag_v, 1'b0}, 32'h0, "reset");
        {mn, mz, mc, mv} = 4'h0;
        p.v = 1'b0;
        sys_rst <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        void'($urandom(12900));
        {sys_rst, op_valid, use_imm, dest_present} = 4'h8;
        op_code = PLAIN_ADD_OP;
        {dest_index, first_src, second_src, first_val, second_val, imm_value} = '0;
        {mismatches, tests_run} = 0;
        idle = mk(PLAIN_ADD_OP, 0, 0, 0, 0, 0, 0, 0, 0);
        idle.v = 1'b0;
        p = idle;
        do_reset();
        step(mk(FLAG_SETTING_ADD_OP, 0, 1, 0, 0, 2, 32'hFFFF_FFFF, 32'h1, 0));
        step(mk(ADD_WITH_CARRY_OP, 0, 0, 0, 1, 3, 32'h0, 32'h0, 0));
        step(mk(PLAIN_ADD_OP, 0, 1, 8, 8, 15, 32'h8000_0000, 32'h8000_0000, 0));
        step(mk(PLAIN_ADD_OP, 0, 1, 15, 15, 15, 32'h4, 32'h4, 0));
        step(mk(FLAG_SETTING_SUBTRACT_OP, 0, 1, 4, 4, 1, 32'h0, 32'h1, 0));
        step(mk(SUBTRACT_WITH_CARRY_OP, 0, 1, 5, 5, 2, 32'h5, 32'h2, 0));
        step(mk(SUBTRACT_WITH_CARRY_OP, 0, 0, 0, 6, 3, 32'h5, 32'h5, 0));
        step(mk(PLAIN_SUBTRACT_OP, 1, 1, 2, 3, 0, 32'h10, 32'h0, 7));
        step(mk(NEGATE_REVERSE_SUBTRACT_OP, 0, 1, 7, 7, 0, 32'h8000_0000, 0, 0));
        step(mk(NEGATE_REVERSE_SUBTRACT_OP, 0, 1, 1, 2, 0, 32'h0, 0, 0));
        step(mk(ADD_WITH_CARRY_OP, 0, 1, 1, 2, 3, 32'h7FFF_FFFF, 32'h0, 0));
        step(mk(ADD_WITH_CARRY_OP, 0, 1, 9, 9, 3, 32'h1, 32'h1, 0));
        step(mk(alu_op_t'(3'h7), 0, 1, 1, 1, 1, 32'h1, 32'h1, 0));
        for (int i = 0; i < 2; i++)
        begin
            step(mk(PLAIN_ADD_OP, 1, 1, 3, PC_INDEX, 0, 32'hFFFF_FFF0, 0, 10'h3FC + 10'(2 * i)));
            step(mk(PLAIN_SUBTRACT_OP, 1, 0, 0, SP_INDEX, 0, 32'h100, 0, 10'h1FC + 10'(4 * i)));
            step(mk(PLAIN_ADD_OP, 1, 1, 5, 6, 0, 32'h9, 0, 10'h7 + 10'(i)));
            step(mk(FLAG_SETTING_ADD_OP, 1, 0, 0, 4, 0, 32'hFFFF_FF01, 0, 10'hFF + 10'(i)));
            step(mk(FLAG_SETTING_SUBTRACT_OP, 1, i[0], 2, 4, 0, 32'h3, 0, 10'h8));
        end
        repeat (4000) step(rnd());
        do_reset();
        repeat (2000) step(rnd());
        step(idle);
        give_verdict();
    end
    // Cuts a hung run short.
    initial
    begin
        #1_000_000;
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
